// ==== rtl/ltm_pkg.sv ====
// Shared constants and types for the bus transceiver mode control.
// Assumes a single 40 MHz clock; all times below are in microseconds.
package ltm_pkg;

    // ----------------------------------------------------------------
    // Clock and times
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 40;
    localparam int unsigned DOM_TIMEOUT_US   = 25000;  // Bus dominant limit
    localparam int unsigned TXD_TIMEOUT_US   = 25000;  // Transmit low limit
    localparam int unsigned WAKE_ORIG_US     = 20;     // Original wake low time
    localparam int unsigned WAKE_DEBOUNCE_US = 80;     // Revised debounce, plain default
    localparam int unsigned CNT_W            = 32;

    // ----------------------------------------------------------------
    // Synchroniser lanes and idle levels
    // ----------------------------------------------------------------
    localparam int unsigned SYN_W    = 4;
    localparam int unsigned SYN_TXD  = 0;
    localparam int unsigned SYN_CS   = 1;
    localparam int unsigned SYN_BUS  = 2;
    localparam int unsigned SYN_TXE  = 3;
    localparam logic [3:0]  SYN_RST  = 4'hD;   // Txd, bus, enable idle high; cs low
    localparam logic        LVL_REC  = 1'b1;   // Recessive / idle level
    localparam logic        LVL_DOM  = 1'b0;
    localparam int unsigned FIFO_W   = 1;
    localparam int unsigned FIFO_D   = 8;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        mode_power_down,
        mode_ready,
        mode_operational,
        transmitter_off_mode
    } ltm_mode_t;

endpackage

// ==== rtl/ltm_fifo_if.sv ====
// Carrier between the mode control and its receive event buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface ltm_fifo_if #(parameter int unsigned W = 1);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// ==== rtl/ltm_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ltm_fifo #(
    parameter int unsigned W     = 1,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic clk,
    input  wire logic srst,
    ltm_fifo_if.fifo  q
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    wire          full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire          empty = (wr_ptr == rd_ptr);
    wire          do_wr = q.push_valid && !full;
    wire          do_rd = q.pop_ready && !empty;

    // ----------------------------------------------------------------
    // Handshake and data
    // ----------------------------------------------------------------
    assign q.push_ready = !full;
    assign q.pop_valid  = !empty;
    assign q.pop_data   = mem[rd_ptr[AW-1:0]];

    // Storage has no reset; only the pointers define contents
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= q.push_data;
        end
    end

    // Pointers carry one extra bit to tell full from empty
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(do_wr);
            rd_ptr <= rd_ptr + (AW+1)'(do_rd);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ltm_timer.sv ====
// Saturating interval timer: counts while run is high, restarts on clear.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ltm_timer #(
    parameter int unsigned LIMIT = 1
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic clear,
    input  wire logic run,
    output logic      expired
);
    logic [ltm_pkg::CNT_W-1:0] cnt;
    localparam logic [ltm_pkg::CNT_W-1:0] LIM = ltm_pkg::CNT_W'(LIMIT);

    assign expired = (cnt >= LIM);

    // Clear beats run so a single idle sample restarts the interval
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            cnt <= '0;
        end else if (run && !expired) begin
            cnt <= cnt + ltm_pkg::CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ltm_mode_ctrl.sv ====
// Mode control of a single-wire bus transceiver: driver steering,
// receive mirror, dominant timeouts, fault indication, regulator enable
// and power-down wake detection.
// Assumes all pins are asynchronous to clk and that the surroundings
// resolve open-drain wires from the output enables.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RQ1: Bus pin is pulled low from the transmit input through an open-drain driver.
// RQ2: Receive output follows the bus level seen by the receiver.
// RQ3: Transmitter switches off after about 25 ms of continuous dominant bus.
// RQ4: Any recessive bus sample restarts the bus dominant timer.
// RQ5: After that shutdown, transmitter returns once bus is recessive and chip select high.
// RQ6: Fault variant pulls its fault pin low during a dominant timeout shutdown.
// RQ7: Regulator enable is high in every mode except power-down.
// RQ8: Original variant wakes on a bus fall held low over 20 us.
// RQ9: Revised variant wakes only on a rise after a low longer than debounce.
// RQ10: Bus pull-up connects on entering operational mode.
// RQ11: Transmit (or enable pin) low at wake-up sends ready to transmitter off.
// RQ12: Host should go operational on bus activity, else back to power-down.
// RQ13: Transmit low over 25 ms forces transmitter off until its next rise.
// RQ14: A disabled transmitter sees the transmit input as logic one.
// RQ15: Ready mode keeps the receiver on and the driver off.
// RQ16: Enable pin low, from fault or host, disables the transmitter.
// RQ17: All timeouts come from an internal timebase with parameter thresholds.
module ltm_mode_ctrl #(
    parameter bit          REVISED     = 1'b1,  // Wake on rise after debounce
    parameter bit          HAS_FAULT   = 1'b1,  // Combined fault/enable pin fitted
    parameter int unsigned DOM_CYCLES  = ltm_pkg::DOM_TIMEOUT_US * ltm_pkg::CLK_MHZ,
    parameter int unsigned TXD_CYCLES  = ltm_pkg::TXD_TIMEOUT_US * ltm_pkg::CLK_MHZ,
    parameter int unsigned WAKE_CYCLES = (REVISED ? ltm_pkg::WAKE_DEBOUNCE_US
                                                  : ltm_pkg::WAKE_ORIG_US) * ltm_pkg::CLK_MHZ
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic txd,
    input  wire logic chip_select,
    input  wire logic bus_line_i,
    output logic      bus_line_o,
    output logic      bus_line_oe,
    output logic      bus_pullup_en,
    output logic      rxd_o,
    output logic      rxd_oe,
    input  wire logic fault_or_tx_enable_pin_i,
    output logic      fault_or_tx_enable_pin_o,
    output logic      fault_or_tx_enable_pin_oe,
    output logic      regulator_enable_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [ltm_pkg::SYN_W-1:0] syn_a;
    logic [ltm_pkg::SYN_W-1:0] syn_b;
    wire  [ltm_pkg::SYN_W-1:0] pins = {fault_or_tx_enable_pin_i, bus_line_i, chip_select, txd};

    // Two stages; only the second stage is read by logic
    always_ff @(posedge clk) begin
        if (srst) begin
            syn_a <= ltm_pkg::SYN_RST;
            syn_b <= ltm_pkg::SYN_RST;
        end else begin
            syn_a <= pins;
            syn_b <= syn_a;
        end
    end

    wire txd_s = syn_b[ltm_pkg::SYN_TXD];
    wire cs_s  = syn_b[ltm_pkg::SYN_CS];
    wire bus_s = syn_b[ltm_pkg::SYN_BUS];
    // Without the fault pin the enable input simply reads as idle
    wire txe_s = HAS_FAULT ? syn_b[ltm_pkg::SYN_TXE] : ltm_pkg::LVL_REC;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ltm_pkg::ltm_mode_t mode;
    ltm_pkg::ltm_mode_t next_mode;
    logic               dom_off;       // Bus dominant timeout shutdown
    logic               txd_prev;      // For transmit rising edge
    logic               wake_seen_hi;  // Bus seen recessive in power-down
    logic               wake_armed;    // Revised: long low completed
    logic               reg_en;
    logic               rx_last;       // Last level pushed to the buffer
    logic               rx_level;      // Level shown on the receive pin
    logic               dom_exp;
    logic               txd_exp;
    logic               wake_exp;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire in_pd      = (mode == ltm_pkg::mode_power_down);
    wire in_oper    = (mode == ltm_pkg::mode_operational);
    wire txd_rise   = txd_s && !txd_prev;
    // Driver only in operational mode, no shutdown, enable pin high
    wire tx_enabled = in_oper && !dom_off && txe_s;                       // RQ15 RQ16
    // Disabled transmitter reads the transmit input as one
    wire txd_int    = tx_enabled ? txd_s : ltm_pkg::LVL_REC;              // RQ14
    wire hold_low   = !txd_s || !txe_s;
    wire wake_low   = in_pd && wake_seen_hi && (bus_s == ltm_pkg::LVL_DOM);
    // Original wakes as soon as the low lasts; revised waits for the rise
    wire bus_wake   = REVISED ? (wake_armed && bus_s)                     // RQ9
                              : wake_exp;                                 // RQ8

    // ----------------------------------------------------------------
    // Timers on the internal timebase
    // ----------------------------------------------------------------
    // Bus dominant timer restarts on every recessive sample
    ltm_timer #(.LIMIT(DOM_CYCLES)) u_dom_timer (                         // RQ17
        .clk     (clk),
        .srst    (srst),
        .clear   (bus_s),                                                 // RQ4
        .run     (!bus_s),
        .expired (dom_exp)
    );

    // Transmit low timer only matters while the driver may act
    ltm_timer #(.LIMIT(TXD_CYCLES)) u_txd_timer (
        .clk     (clk),
        .srst    (srst),
        .clear   (txd_s || !in_oper),
        .run     (!txd_s),
        .expired (txd_exp)
    );

    // Wake low-time measured from a fall seen in power-down
    ltm_timer #(.LIMIT(WAKE_CYCLES)) u_wake_timer (
        .clk     (clk),
        .srst    (srst),
        .clear   (!wake_low),
        .run     (wake_low),
        .expired (wake_exp)
    );

    // ----------------------------------------------------------------
    // Mode sequencing
    // ----------------------------------------------------------------
    // Host leaves power-down by chip select high or the bus wakes it;
    // host returns to power-down from operational or transmitter off by taking chip select low; ready ignores it
    always_comb begin
        next_mode = mode;
        case (mode)
            ltm_pkg::mode_power_down: begin
                if (bus_wake || cs_s) begin
                    next_mode = ltm_pkg::mode_ready;
                end
            end
            ltm_pkg::mode_ready: begin
                if (cs_s && hold_low) begin
                    next_mode = ltm_pkg::transmitter_off_mode;            // RQ11
                end else if (cs_s) begin
                    next_mode = ltm_pkg::mode_operational;
                end
            end
            ltm_pkg::mode_operational: begin
                if (!cs_s) begin
                    next_mode = ltm_pkg::mode_power_down;
                end else if (txd_exp) begin
                    next_mode = ltm_pkg::transmitter_off_mode;            // RQ13
                end
            end
            ltm_pkg::transmitter_off_mode: begin
                if (!cs_s) begin
                    next_mode = ltm_pkg::mode_power_down;
                end else if (txd_rise && txe_s) begin
                    next_mode = ltm_pkg::mode_operational;                // RQ13
                end
            end
            default: begin
                next_mode = ltm_pkg::mode_ready;
            end
        endcase
    end

    // Mode register and regulator enable follow the same decision
    always_ff @(posedge clk) begin
        if (srst) begin
            mode   <= ltm_pkg::mode_ready;
            reg_en <= 1'b1;
        end else begin
            mode   <= next_mode;
            reg_en <= (next_mode != ltm_pkg::mode_power_down);            // RQ7
        end
    end

    // Dominant shutdown; set beats clear, because on the first recessive
    // sample the timer has not restarted yet, so the flag holds one more cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            dom_off <= 1'b0;
        end else if (dom_exp) begin
            dom_off <= 1'b1;                                              // RQ3
        end else if (bus_s && cs_s) begin
            dom_off <= 1'b0;                                              // RQ5
        end
    end

    // Edge and wake qualifiers
    always_ff @(posedge clk) begin
        if (srst) begin
            txd_prev     <= ltm_pkg::LVL_REC;
            wake_seen_hi <= 1'b0;
            wake_armed   <= 1'b0;
        end else begin
            txd_prev     <= txd_s;
            wake_seen_hi <= in_pd && (wake_seen_hi || bus_s);
            wake_armed   <= in_pd && (wake_armed || wake_exp);
        end
    end

    // ----------------------------------------------------------------
    // Receive path through the event buffer
    // ----------------------------------------------------------------
    // Level changes queue up; a full buffer holds rx_last so the change
    // is retried. The drain stalls in power-down, when the receiver is off.
    ltm_fifo_if #(.W(ltm_pkg::FIFO_W)) rxq ();

    assign rxq.push_valid = (bus_s != rx_last);
    assign rxq.push_data  = bus_s;
    assign rxq.pop_ready  = !in_pd;

    ltm_fifo #(.W(ltm_pkg::FIFO_W), .DEPTH(ltm_pkg::FIFO_D)) u_rx_fifo (
        .clk  (clk),
        .srst (srst),
        .q    (rxq.fifo)
    );

    // Receive level tracks the bus with a few cycles of latency
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_last  <= ltm_pkg::LVL_REC;
            rx_level <= ltm_pkg::LVL_REC;
        end else begin
            if (rxq.push_valid && rxq.push_ready) begin
                rx_last <= bus_s;
            end
            if (rxq.pop_valid && rxq.pop_ready) begin
                rx_level <= rxq.pop_data;                                 // RQ2
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Open-drain pins only ever drive low
    assign bus_line_o                = ltm_pkg::LVL_DOM;
    assign bus_line_oe               = !txd_int;                          // RQ1
    assign bus_pullup_en             = in_oper && txe_s;                  // RQ10
    assign rxd_o                     = ltm_pkg::LVL_DOM;
    // Receiver is off and the pin floats in power-down
    assign rxd_oe                    = !in_pd && !rx_level;               // RQ2 RQ15
    assign fault_or_tx_enable_pin_o  = ltm_pkg::LVL_DOM;
    assign fault_or_tx_enable_pin_oe = HAS_FAULT && dom_off;              // RQ6 RQ16
    assign regulator_enable_out      = reg_en;
endmodule
`default_nettype wire

// ==== verification/ltm_bus_model.sv ====
// Far-side model: the bus wire with its master pull-up and the host's
// enable pin. Assumes the bench drives the other node and the host pins.
`timescale 1ns/10ps
`default_nettype none
module ltm_bus_model (
    input  wire logic ext_dom,
    input  wire logic host_en_low,
    input  wire logic dev_bus_oe,
    input  wire logic dev_fault_oe,
    output logic      bus_line,
    output logic      fault_pin
);
    // Wired-AND bus; the master pull-up makes released means recessive
    assign bus_line  = ~(dev_bus_oe | ext_dom);
    // Enable pin: pulled low by device fault or host, else pulled up
    assign fault_pin = ~(dev_fault_oe | host_en_low);
endmodule
`default_nettype wire

// ==== verification/ltm_mode_ctrl_checker.sv ====
// Port-level checker for the mode control top.
// Assumes pins reach logic after two sync flops.
`timescale 1ns/10ps
`default_nettype none
module ltm_mode_ctrl_checker #(
    parameter int unsigned DOM_CYCLES = 100,
    parameter bit          REVISED    = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic txd,
    input wire logic chip_select,
    input wire logic bus_line_i,
    input wire logic bus_line_o,
    input wire logic bus_line_oe,
    input wire logic bus_pullup_en,
    input wire logic rxd_o,
    input wire logic rxd_oe,
    input wire logic fault_or_tx_enable_pin_i,
    input wire logic fault_or_tx_enable_pin_o,
    input wire logic fault_or_tx_enable_pin_oe,
    input wire logic regulator_enable_out
);
    int unsigned low_run;

    // Consecutive dominant samples; saturates so it never wraps
    always_ff @(posedge clk) begin
        if (srst || bus_line_i) begin
            low_run <= 0;
        end else if (low_run < DOM_CYCLES + 16) begin
            low_run <= low_run + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_drive_from_txd: assert property (
        bus_line_oe |-> !$past(txd, 2) || !$past(txd, 3)) else $error("drive without txd low");
    a_dom_needs_run: assert property (
        $rose(fault_or_tx_enable_pin_oe) |-> low_run >= DOM_CYCLES) else $error("early timeout");
    a_fault_holds: assert property (
        fault_or_tx_enable_pin_oe && !$past(bus_line_i) && !$past(bus_line_i, 2)
        |-> ##2 fault_or_tx_enable_pin_oe)
        else $error("fault cleared while dominant");
    a_od_low_only: assert property (
        !bus_line_o && !rxd_o && !fault_or_tx_enable_pin_o)
        else $error("open-drain pin driven high");
    a_fault_blocks: assert property (
        fault_or_tx_enable_pin_oe |-> !bus_line_oe) else $error("drive during fault");
    a_enable_blocks: assert property (
        bus_line_oe |-> $past(fault_or_tx_enable_pin_i, 2) || $past(fault_or_tx_enable_pin_i, 3))
        else $error("drive with enable low");
    a_pd_silent: assert property (
        !regulator_enable_out |-> !bus_line_oe && !rxd_oe && !bus_pullup_en)
        else $error("activity in power-down");
    a_pullup_needs_en: assert property (
        bus_pullup_en |-> regulator_enable_out && $past(fault_or_tx_enable_pin_i, 2))
        else $error("pull-up without enable");
    a_wake_cause: assert property (
        $rose(regulator_enable_out) |-> $past(chip_select, 3) || $past(chip_select, 4)
        || (REVISED && ($past(bus_line_i, 2) || $past(bus_line_i, 3))
        && !($past(bus_line_i, 4) && $past(bus_line_i, 5) && $past(bus_line_i, 6)))
        || (!REVISED && (!$past(bus_line_i, 3) || !$past(bus_line_i, 4))))
        else $error("wake without cause");

    c_fault: cover property ($rose(fault_or_tx_enable_pin_oe));
    c_wake: cover property ($rose(regulator_enable_out));
    c_drive: cover property ($rose(bus_line_oe));
endmodule

bind ltm_mode_ctrl ltm_mode_ctrl_checker #(.DOM_CYCLES(DOM_CYCLES), .REVISED(REVISED)) u_chk (
    .clk(clk), .srst(srst), .txd(txd), .chip_select(chip_select),
    .bus_line_i(bus_line_i), .bus_line_o(bus_line_o), .bus_line_oe(bus_line_oe),
    .bus_pullup_en(bus_pullup_en), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
    .fault_or_tx_enable_pin_i(fault_or_tx_enable_pin_i),
    .fault_or_tx_enable_pin_o(fault_or_tx_enable_pin_o),
    .fault_or_tx_enable_pin_oe(fault_or_tx_enable_pin_oe),
    .regulator_enable_out(regulator_enable_out));
`default_nettype wire

// ==== verification/lin_transceiver_mode_control_bench.sv ====
// Self-checking bench for the mode control with a bus/host far side.
// Assumes shortened timeouts; inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module lin_transceiver_mode_control_bench;
    localparam int unsigned DOM = 100;
    localparam int unsigned TXO = 60;
    localparam int unsigned WAKE = 10;
    logic clk, srst, txd, chip_select, ext_dom, host_en_low;
    logic bus_line, fault_pin, bus_line_oe, bus_pullup_en, rxd_oe, fault_oe, regulator_enable_out;
    logic orig_reg_en;
    int   mismatches, checks_done, seed, exp_drive;
    int   bits[$];

    ltm_mode_ctrl #(.REVISED(1'b1), .HAS_FAULT(1'b1), .DOM_CYCLES(DOM), .TXD_CYCLES(TXO),
        .WAKE_CYCLES(WAKE)) u_dut (
        .clk(clk), .srst(srst), .txd(txd), .chip_select(chip_select), .bus_line_i(bus_line),
        .bus_line_o(), .bus_line_oe(bus_line_oe), .bus_pullup_en(bus_pullup_en), .rxd_o(),
        .rxd_oe(rxd_oe), .fault_or_tx_enable_pin_i(fault_pin), .fault_or_tx_enable_pin_o(),
        .fault_or_tx_enable_pin_oe(fault_oe), .regulator_enable_out(regulator_enable_out));
    // Original wake variant without the fault pin; it shares txd, chip select and bus, only its regulator enable is observed
    ltm_mode_ctrl #(.REVISED(1'b0), .HAS_FAULT(1'b0), .DOM_CYCLES(DOM), .TXD_CYCLES(TXO),
        .WAKE_CYCLES(WAKE)) u_dut_orig (
        .clk(clk), .srst(srst), .txd(txd), .chip_select(chip_select), .bus_line_i(bus_line),
        .bus_line_o(), .bus_line_oe(), .bus_pullup_en(), .rxd_o(), .rxd_oe(),
        .fault_or_tx_enable_pin_i(1'b1), .fault_or_tx_enable_pin_o(),
        .fault_or_tx_enable_pin_oe(), .regulator_enable_out(orig_reg_en));
    ltm_bus_model u_far (.ext_dom(ext_dom), .host_en_low(host_en_low), .dev_bus_oe(bus_line_oe),
        .dev_fault_oe(fault_oe), .bus_line(bus_line), .fault_pin(fault_pin));

    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait on fault (0) or regulator (1); running out ends the run
    task automatic wait_for(input int which, input logic val, input int limit);
        int i;
        for (i = 0; i < limit; i++) begin
            if ((which == 0 ? fault_oe : regulator_enable_out) === val) break;
            @(negedge clk);
        end
        cmp(val, which == 0 ? fault_oe : regulator_enable_out);
        if (i == limit) final_report();
    endtask

    initial begin
        seed = 2839;
        srst = 1'b1; txd = 1'b1; chip_select = 1'b0; ext_dom = 1'b0; host_en_low = 1'b0;
        mismatches = 0; checks_done = 0;
        step(10);
        srst = 1'b0;
        step(3);
        // Ready: regulator on, driver and pull-up off whatever txd does
        cmp(1'b1, regulator_enable_out);
        txd = 1'b0; step(5);
        cmp(1'b0, bus_line_oe);
        cmp(1'b0, bus_pullup_en);
        txd = 1'b1; chip_select = 1'b1; step(5);
        cmp(1'b1, bus_pullup_en);
        // Random bits; every fourth is recessive to stay below the txd timeout
        for (int i = 0; i < 24; i++) begin
            txd = (i % 4 == 3) ? 1'b1 : 1'($random(seed));
            bits.push_back(txd ? 0 : 1);
            step(8);
            exp_drive = bits.pop_front();
            cmp(exp_drive[0], bus_line_oe);
            cmp(exp_drive[0], rxd_oe);
        end
        txd = 1'b1; step(4);
        // Two dominant stretches short of the limit split by a recessive gap
        repeat (2) begin
            ext_dom = 1'b1; step(DOM - 20);
            ext_dom = 1'b0; step(3);
        end
        cmp(1'b0, fault_oe);
        ext_dom = 1'b1;
        wait_for(0, 1'b1, DOM + 20);
        step(3);
        cmp(1'b0, bus_pullup_en);
        txd = 1'b0; step(6);
        cmp(1'b0, bus_line_oe);
        txd = 1'b1; step(20);
        cmp(1'b1, fault_oe);
        ext_dom = 1'b0;
        wait_for(0, 1'b0, 10);
        txd = 1'b0; step(5);
        cmp(1'b1, bus_line_oe);
        // Host pulls the enable pin low
        txd = 1'b1; step(4);
        host_en_low = 1'b1; txd = 1'b0; step(6);
        cmp(1'b0, bus_line_oe);
        cmp(1'b0, bus_pullup_en);
        host_en_low = 1'b0; step(5);
        cmp(1'b1, bus_line_oe);
        txd = 1'b1; step(4);
        // Transmit stuck low
        txd = 1'b0; step(TXO - 10);
        cmp(1'b1, bus_line_oe);
        step(20);
        cmp(1'b0, bus_line_oe);
        cmp(1'b0, fault_oe);
        txd = 1'b1; step(5);
        txd = 1'b0; step(5);
        cmp(1'b1, bus_line_oe);
        txd = 1'b1; step(4);
        // Power-down, a short low pulse must not wake, a long one then a rise must
        chip_select = 1'b0;
        wait_for(1, 1'b0, 8);
        ext_dom = 1'b1; step(4);
        ext_dom = 1'b0; step(WAKE + 10);
        cmp(1'b0, regulator_enable_out);
        cmp(1'b0, rxd_oe);
        cmp(1'b0, orig_reg_en);
        ext_dom = 1'b1; step(WAKE + 10);
        cmp(1'b0, regulator_enable_out);
        cmp(1'b1, orig_reg_en);
        txd = 1'b0; ext_dom = 1'b0;
        wait_for(1, 1'b1, 8);
        step(3);
        cmp(1'b0, bus_line_oe);
        chip_select = 1'b1; step(6);
        cmp(1'b0, bus_line_oe);
        cmp(1'b0, bus_pullup_en);
        txd = 1'b1; step(5);
        txd = 1'b0; step(5);
        cmp(1'b1, bus_line_oe);
        txd = 1'b1; step(4);
        final_report();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
